// >>> common/sps_params.svh
// constants of the soft-start and protection supervisor
// Operation
// - At start-up the reference ramps from zero to the final value over exactly 2048 clocks by a counter.
// - Both phases switch under closed loop as soon as the ramp begins.
// - Power-good is held low for the whole ramp.
// - The power-good window check is enabled only after the ramp ends, 2048 clocks after start.
// - Once enabled, power-good is low outside plus or minus 12% of the target and released otherwise.
// - Output below 60% of the reference for more than one clock stops switching and restarts the ramp.
// - The undervoltage check is armed only once the ramping reference reaches 0.6V.
// - The undervoltage threshold follows the ramping reference; the overvoltage one uses the final value.
// - The overvoltage check is active in every state, ramp included, against the final reference.
// - Overvoltage protection is armed once the control supply is above its turn-on threshold.
// - At 115% of the target both low-side switches latch on and both high-side switches off.
// - An overvoltage latch drives the fault pin high; only the asynchronous reset restarts the part, not a control supply cycle.
// - The ramp never starts unless both control and driver supplies are flagged good.
// - In operation a low flag on either supply shuts the device down.
// - While the inhibit pin is held low, switches and protections are off until it is released.
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_SS_STEPS    12'h800
`define SPS_UV_ARM_MV   12'h258
`define SPS_PG_LO_PCT   7'h58
`define SPS_PG_HI_PCT   7'h70
`define SPS_UV_PCT      7'h3c
`define SPS_OV_PCT      7'h73
`define SPS_PCT_ONE     7'h64
`define SPS_A_CTRL      8'h00
`define SPS_A_REF       8'h04
`define SPS_A_STAT      8'h08
`define SPS_A_CNT       8'h0c
`define SPS_A_ISTAT     8'h10
`define SPS_A_ICLR      8'h14
`define SPS_A_IEN       8'h18
`define SPS_CTRL_RST    1'b1
`define SPS_REF_RST     12'h4b0
`define SPS_EV_DONE     0
`define SPS_EV_UV       1
`define SPS_EV_OV       2
`define SPS_EV_SUP      3
`endif

// >>> common/sps_pkg.sv
// types of the soft-start and protection supervisor
package sps_pkg;
    typedef enum logic [2:0] {
        SPS_OFF,
        SPS_RAMP,
        SPS_RUN,
        SPS_HICCUP,
        SPS_LATCH
    } sps_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sps_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sps_apb_rsp_t;

    typedef struct packed {
        logic [1:0] hs_sw;
        logic [1:0] ls_sw;
        logic [1:0] hs_off;
        logic [1:0] ls_on;
    } sps_gate_t;

    typedef struct packed {
        sps_state_t  st;
        logic [11:0] cnt;
        logic [11:0] refc;
        logic        uv_seen;
        logic        ov;
        logic        pg;
        logic        run;
        logic [11:0] fin;
        logic [3:0]  ist;
        logic [3:0]  ien;
        logic [31:0] rdata;
        logic        slverr;
        logic [1:0]  vcc_s;
        logic [1:0]  drv_s;
        logic [1:0]  inh_s;
    } sps_regs_t;
endpackage : sps_pkg

// >>> hdl/sps_supervisor.sv
// soft-start, power-good and over/under-voltage supervisor with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "sps_params.svh"
module sps_supervisor
    import sps_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire sps_apb_req_t apb_req,
    output var  sps_apb_rsp_t apb_rsp,
    input  wire logic [11:0]  sensed_output_pin,
    input  wire logic         control_supply_ok,
    input  wire logic         driver_supply_ok,
    input  wire logic         oscillator_inhibit_pin,
    output var  sps_gate_t    gate,
    output logic [11:0]       ref_code,
    output logic              power_ok_output_o,
    output logic              power_ok_output_oe,
    output logic              oscillator_fault_pin,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////
    function automatic logic [19:0] pct(input logic [11:0] v, input logic [6:0] p);
        pct = 20'(v) * 20'(p);
    endfunction : pct

    sps_regs_t r;
    sps_regs_t n;

    logic        inhibit;
    logic        sup_ok;
    logic [19:0] sen_x100;
    logic        uv_below;
    logic        ov_hit;
    logic        pg_in;
    logic [23:0] ramp_prod;
    logic        wr;
    logic        rd_setup;
    logic [3:0]  ev;

    assign inhibit  = ~r.inh_s[1];
    assign sup_ok   = r.vcc_s[1] & r.drv_s[1];
    assign sen_x100 = pct(sensed_output_pin, `SPS_PCT_ONE);
    // threshold follows the ramp during soft-start
    assign uv_below = (r.refc >= `SPS_UV_ARM_MV) && (sen_x100 < pct(r.refc, `SPS_UV_PCT));
    // overvoltage always against the final target, ramp or not
    assign ov_hit   = sen_x100 >= pct(r.fin, `SPS_OV_PCT);
    assign pg_in    = (sen_x100 >= pct(r.fin, `SPS_PG_LO_PCT)) && (sen_x100 <= pct(r.fin, `SPS_PG_HI_PCT));
    assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup = apb_req.psel & ~apb_req.penable;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        n          = r;
        ev         = 4'h0;
        ramp_prod  = 24'h0;
        n.vcc_s    = {r.vcc_s[0], control_supply_ok};
        n.drv_s    = {r.drv_s[0], driver_supply_ok};
        n.inh_s    = {r.inh_s[0], oscillator_inhibit_pin};
        n.uv_seen  = 1'b0;

        unique case (r.st)
            SPS_OFF: begin
                n.cnt = 12'h000;
                n.pg  = 1'b0;
                if (sup_ok && r.run && !inhibit) begin
                    n.st = SPS_RAMP;
                end
            end
            SPS_RAMP: begin
                n.pg  = 1'b0;
                n.cnt = r.cnt + 12'h001;
                if (r.cnt + 12'h001 == `SPS_SS_STEPS) begin
                    n.st = SPS_RUN;
                    ev[`SPS_EV_DONE] = 1'b1;
                end
            end
            SPS_RUN: begin
                n.pg = pg_in;
            end
            SPS_HICCUP: begin
                // one dead cycle with all gates off before ramping anew
                n.cnt = 12'h000;
                n.pg  = 1'b0;
                n.st  = SPS_RAMP;
            end
            SPS_LATCH: begin
                n.pg = 1'b0;
            end
        endcase

        if ((r.st == SPS_RAMP || r.st == SPS_RUN) && uv_below) begin
            n.uv_seen = 1'b1;
            // second low sample in a row: more than one clock period
            if (r.uv_seen) begin
                n.st      = SPS_HICCUP;
                n.cnt     = 12'h000;
                n.pg      = 1'b0;
                n.uv_seen = 1'b0;
                ev[`SPS_EV_UV] = 1'b1;
            end
        end

        // a hiccup restart must not ramp on a lost supply either
        if ((r.st == SPS_RAMP || r.st == SPS_RUN || r.st == SPS_HICCUP) && !sup_ok) begin
            n.st  = SPS_OFF;
            n.cnt = 12'h000;
            n.pg  = 1'b0;
            ev[`SPS_EV_SUP] = 1'b1;
        end

        if (inhibit && r.st != SPS_LATCH) begin
            n.st      = SPS_OFF;
            n.cnt     = 12'h000;
            n.pg      = 1'b0;
            n.uv_seen = 1'b0;
        end

        // armed by the control supply only; inhibit turns it off
        if (r.vcc_s[1] && !inhibit && ov_hit && !r.ov) begin
            n.ov = 1'b1;
            n.st = SPS_LATCH;
            n.pg = 1'b0;
            ev[`SPS_EV_OV] = 1'b1;
        end
        if (r.ov) begin
            n.st = SPS_LATCH;
        end

        ramp_prod = 24'(r.fin) * 24'(n.cnt);
        n.refc    = (n.st == SPS_RAMP) ? ramp_prod[22:11] :
                    (n.st == SPS_RUN)  ? r.fin : 12'h000;

        // register writes take effect in the access phase
        if (wr) begin
            unique case (apb_req.paddr)
                `SPS_A_CTRL: n.run = apb_req.pwdata[0];
                `SPS_A_REF:  n.fin = apb_req.pwdata[11:0];
                `SPS_A_IEN:  n.ien = apb_req.pwdata[3:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        n.ist = (r.ist & ~((wr && apb_req.paddr == `SPS_A_ICLR) ? apb_req.pwdata[3:0] : 4'h0)) | ev;

        // read data captured in the setup cycle, answered in the access cycle
        if (rd_setup) begin
            n.slverr = 1'b0;
            n.rdata  = 32'h0;
            unique case (apb_req.paddr)
                `SPS_A_CTRL:  n.rdata = {31'h0, r.run};
                `SPS_A_REF:   n.rdata = {20'h0, r.fin};
                `SPS_A_STAT:  n.rdata = {25'h0, r.ov, r.pg, sup_ok, inhibit, r.st};
                `SPS_A_CNT:   n.rdata = {20'h0, r.cnt};
                `SPS_A_ISTAT: n.rdata = {28'h0, r.ist};
                `SPS_A_ICLR:  n.rdata = 32'h0;
                `SPS_A_IEN:   n.rdata = {28'h0, r.ien};
                default:      n.slverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r         <= '0;
            r.st      <= SPS_OFF;
            r.run     <= `SPS_CTRL_RST;
            r.fin     <= `SPS_REF_RST;
            r.inh_s   <= 2'b11;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        gate = '0;
        if (r.st == SPS_LATCH && !inhibit) begin
            gate.hs_off = 2'b11;
            gate.ls_on  = 2'b11;
        end else if (r.st == SPS_RAMP || r.st == SPS_RUN) begin
            gate.hs_sw = 2'b11;
            gate.ls_sw = 2'b11;
        end
    end

    assign ref_code             = r.refc;
    // open drain: drive low unless the window is good
    assign power_ok_output_o    = 1'b0;
    assign power_ok_output_oe   = ~r.pg;
    assign oscillator_fault_pin = r.ov;
    assign irq                  = |(r.ist & r.ien);
    // zero wait states: every access completes in its first access cycle
    assign apb_rsp              = '{pready: 1'b1,
                                    pslverr: r.slverr & apb_req.psel & apb_req.penable,
                                    prdata: r.rdata};

endmodule : sps_supervisor
`default_nettype wire

// >>> dv/sps_supervisor_props.sv
// assertion checker on the supervisor ports
`timescale 1ns/100ps
`default_nettype none
module sps_supervisor_props
    import sps_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [11:0] sensed_output_pin,
    input wire logic        control_supply_ok,
    input wire logic        driver_supply_ok,
    input wire logic        oscillator_inhibit_pin,
    input wire sps_gate_t   gate,
    input wire logic [11:0] ref_code,
    input wire logic        power_ok_output_oe,
    input wire logic        oscillator_fault_pin
);
    logic [11:0] rc_r;
    logic [31:0] s100;
    logic [31:0] r1;
    assign s100 = 32'(sensed_output_pin) * 32'd100;
    assign r1   = 32'(ref_code);
    // cycles since switching began; the one-cycle hiccup gap clears it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rc_r <= 12'h000;
        else if (gate.hs_sw == 2'b00) rc_r <= 12'h000;
        else if (rc_r != 12'hfff) rc_r <= rc_r + 12'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_phase_pair: assert property (gate.hs_sw == gate.ls_sw && gate.hs_sw != 2'b01 && gate.hs_sw != 2'b10)
        else $error("phase gates out of step");
    a_pg_ramp_low: assert property (gate.hs_sw != 2'b00 && rc_r < 12'd2048 |-> power_ok_output_oe)
        else $error("power good released during ramp");
    a_pg_window: assert property (!power_ok_output_oe |-> $past(s100) >= r1 * 88 && $past(s100) <= r1 * 112)
        else $error("power good released outside window");
    a_ov_trip: assert property (rc_r > 12'd2050 && gate.hs_sw == 2'b11 && s100 >= r1 * 115 |=> oscillator_fault_pin)
        else $error("overvoltage not latched");
    a_fault_hold: assert property (oscillator_fault_pin |=> oscillator_fault_pin)
        else $error("fault latch lost");
    a_crowbar_on: assert property (oscillator_fault_pin && oscillator_inhibit_pin && $past(oscillator_inhibit_pin)
        && $past(oscillator_inhibit_pin, 2) && $past(oscillator_inhibit_pin, 3) |-> gate == 8'h0f)
        else $error("crowbar not driven");
    a_inhibit_off: assert property (!oscillator_inhibit_pin && !$past(oscillator_inhibit_pin)
        && !$past(oscillator_inhibit_pin, 2) && !$past(oscillator_inhibit_pin, 3) |-> gate == 8'h00)
        else $error("switching while inhibited");
    a_supply_off: assert property (!(control_supply_ok && driver_supply_ok) && !$past(control_supply_ok && driver_supply_ok)
        && !$past(control_supply_ok && driver_supply_ok, 2) && !$past(control_supply_ok && driver_supply_ok, 3)
        |-> gate.hs_sw == 2'b00)
        else $error("switching without supplies");
endmodule : sps_supervisor_props
bind sps_supervisor sps_supervisor_props props_i (.clk(clk), .arst_n(arst_n), .sensed_output_pin(sensed_output_pin),
    .control_supply_ok(control_supply_ok), .driver_supply_ok(driver_supply_ok), .gate(gate), .ref_code(ref_code),
    .oscillator_inhibit_pin(oscillator_inhibit_pin), .power_ok_output_oe(power_ok_output_oe),
    .oscillator_fault_pin(oscillator_fault_pin));
`default_nettype wire

// >>> dv/sps_plant.sv
// output stage and comparator model seen by the supervisor
`timescale 1ns/100ps
`default_nettype none
module sps_plant
    import sps_pkg::*;
(
    input  wire logic        clk,
    input  wire sps_gate_t   gate,
    input  wire logic [11:0] ref_code,
    input  wire logic [1:0]  mode,
    input  wire logic [11:0] fv,
    output var  logic [11:0] sen
);
    // mode 2 forces a level even with gates off, 1 sags to 70%, 0 tracks; in other modes output collapses when gates stop
    always_ff @(posedge clk) begin
        if (mode == 2'h2) sen <= fv;
        else if (gate.hs_sw == 2'b00) sen <= 12'h000;
        else sen <= (mode == 2'h1) ? 12'(32'(ref_code) * 7 / 10) : ref_code;
    end
endmodule : sps_plant
`default_nettype wire

// >>> dv/sps_supervisor_bench.sv
// self-checking bench of the soft-start supervisor
`timescale 1ns/100ps
`default_nettype none
`include "sps_params.svh"
module sps_supervisor_bench
    import sps_pkg::*;
;
    logic         clk = 1'b0, arst_n = 1'b0, cs = 1'b0, ds = 1'b0, inh = 1'b1;
    sps_apb_req_t rq = '0;
    sps_apb_rsp_t rsp;
    sps_gate_t    gate;
    logic [11:0]  sen, refc, fv = 12'h000, fin = 12'h4b0;
    logic [1:0]   mode = 2'h0;
    logic         po, poe, flt, irq, er;
    logic [31:0]  rd;
    integer       seed = 39711, n_mismatch = 0, checked = 0, cyc = 0, i;
    always #50 clk = ~clk;
    sps_supervisor sps_supervisor_i (.clk(clk), .arst_n(arst_n), .apb_req(rq), .apb_rsp(rsp),
        .sensed_output_pin(sen), .control_supply_ok(cs), .driver_supply_ok(ds), .oscillator_inhibit_pin(inh),
        .gate(gate), .ref_code(refc), .power_ok_output_o(po), .power_ok_output_oe(poe),
        .oscillator_fault_pin(flt), .irq(irq));
    sps_plant sps_plant_i (.clk(clk), .gate(gate), .ref_code(refc), .mode(mode), .fv(fv), .sen(sen));
    ////////////////////////////////////////////////////////////////
    function automatic logic pg_exp(input logic [11:0] s, input logic [11:0] f);
        pg_exp = 32'(s) * 100 >= 32'(f) * 88 && 32'(s) * 100 <= 32'(f) * 112;
    endfunction : pg_exp
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked = checked + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // settle past the edge so registered outputs have landed
    task cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cy
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) rq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) rq.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        rq <= '0;
    endtask : apb
    task on_wait;
        for (i = 0; i < 300 && gate.hs_sw !== 2'b11; i++) @(posedge clk);
    endtask : on_wait
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, `SPS_A_CTRL, 32'h0); chk(rd, 32'h1);
        apb(1'b0, `SPS_A_REF, 32'h0); chk(rd, 32'h4b0);
        apb(1'b0, 8'h40, 32'h0); chk({31'h0, er}, 32'h1);
        apb(1'b1, `SPS_A_IEN, 32'hf);
        @(posedge clk) begin cs <= 1'b1; mode <= 2'h2; end
        cy(30); chk(32'(gate), 32'h0);
        @(posedge clk) ds <= 1'b1;
        on_wait;
        cy(200); chk(32'(gate), 32'hf0);
        @(posedge clk) mode <= 2'h1;
        cy(823); chk(32'(refc >= 12'd597 && refc <= 12'd603), 32'h1);
        cy(1000); chk(32'(refc < fin), 32'h1);
        cy(40); chk(32'(refc), 32'(fin));
        chk(32'(poe), 32'h1);
        chk(32'(po), 32'h0);
        apb(1'b0, `SPS_A_ISTAT, 32'h0); chk(rd, 32'h1);
        apb(1'b0, `SPS_A_CNT, 32'h0); chk(rd, 32'(`SPS_SS_STEPS));
        cy(1); chk(32'(irq), 32'h1);
        for (int k = 0; k < 15; k++) begin
            @(posedge clk) fv <= (k == 0) ? 12'd1056 : (k == 1) ? 12'd1344 : (k == 2) ? 12'd1055
                : 12'd720 + 12'($unsigned($random(seed)) % 650);
            @(posedge clk) mode <= 2'h2;
            cy(3); chk(32'(poe), 32'(!pg_exp(fv, fin)));
        end
        apb(1'b1, `SPS_A_ICLR, 32'hf);
        cy(1); chk(32'(irq), 32'h0);
        @(posedge clk) fv <= 12'd500;
        cy(8); chk(32'(refc < 12'd20 && poe), 32'h1);
        @(posedge clk) mode <= 2'h0;
        apb(1'b0, `SPS_A_ISTAT, 32'h0); chk(rd & 32'h2, 32'h2);
        cy(1); chk(32'(irq), 32'h1);
        apb(1'b1, `SPS_A_IEN, 32'h0);
        cy(1); chk(32'(irq), 32'h0);
        apb(1'b1, `SPS_A_IEN, 32'hf);
        cy(2100); chk(32'(poe), 32'h0);
        @(posedge clk) inh <= 1'b0;
        cy(6); chk(32'(gate), 32'h0);
        @(posedge clk) inh <= 1'b1;
        on_wait;
        cy(1); chk(32'(refc < 12'd20), 32'h1);
        cy(2100); chk(32'(gate), 32'hf0);
        @(posedge clk) ds <= 1'b0;
        cy(6); chk(32'(gate), 32'h0);
        @(posedge clk) begin ds <= 1'b1; fv <= 12'd1379; mode <= 2'h2; end
        cy(8); chk(32'(flt), 32'h0);
        @(posedge clk) fv <= 12'd1380;
        cy(4); chk(32'(flt), 32'h1);
        chk(32'(gate), 32'h0f);
        @(posedge clk) begin inh <= 1'b0; cs <= 1'b0; mode <= 2'h0; end
        cy(6);
        @(posedge clk) begin inh <= 1'b1; cs <= 1'b1; end
        cy(20); chk(32'(flt), 32'h1);
        apb(1'b0, `SPS_A_STAT, 32'h0); chk(rd, 32'h54);
        @(posedge clk) arst_n <= 1'b0;
        @(posedge clk) arst_n <= 1'b1;
        cy(2); chk(32'(flt), 32'h0);
        // new target, then an overvoltage trip from the settled run state
        apb(1'b1, `SPS_A_REF, 32'h3e8);
        fin = 12'h3e8;
        cy(2100); chk(32'(refc), 32'(fin));
        chk(32'(poe), 32'h0);
        @(posedge clk) begin fv <= 12'd1150; mode <= 2'h2; end
        cy(4); chk(32'(flt), 32'h1);
        chk(32'(gate), 32'h0f);
        close_out;
    end
endmodule : sps_supervisor_bench
`default_nettype wire
